// ---- bpi_ctrl.sv ----
// Purpose: Protection states, operating mode and lamp drive of a pack supervisor.
// Assumes: Measurements come from logic on clk; button and switch are raw pins.
// Notes: Voltages in mV, currents in the caller's unit, charge level in percent.
// Overview of operation
// - Patterns: beacon 0.25/3.75 s, even 0.5/0.5 s, medium 0.5/1.5 s.
// - Discharging: run lamp medium blink, alarm dark, level lamps steady.
// - Discharge protection stops discharge, alarm only; sleep after 24 h without charger.
// - Button boot with no protection active enters standby.
// - Standby shows run lamp, both paths enabled.
// - Any cell above cell overcharge threshold disables charging.
// - Cell overcharge clears below recovery with level under 96%, or on discharge.
// - Pack above pack overcharge threshold disables charging.
// - Pack overcharge clears below recovery with level under 96%.
// - Any cell below cell over-discharge threshold disables discharging.
// - Pack below pack over-discharge threshold disables discharging.
// - After over-discharge, keep communication one minute, then power down.
// - Charging releases over-discharge; button reboots and re-checks.
// - Charge overcurrent held for delay, without current limiting, disables charging.
// - Charge overcurrent recovers after delay and re-measures; discharge clears it.
// - Discharge overcurrent held for delay disables discharging.
// - Discharge overcurrent recovers after delay and re-measures; charging clears it.
// - Transient overcurrent latches after a count; only reboot or charging clears.
// - Charging when charger exceeds pack by 0.5 V and current is effective.
// - Shutdown after 24 h standby, undervoltage, or button or switch command.
// - Lamps: one run, one alarm, four level lamps.
`timescale 1ns/1ns
`include "bpi_consts.svh"
module bpi_ctrl #(
    parameter int VW = 16,
    parameter int IW = 16,
    parameter int TICK_CYC = `BPI_TICK_CYC,
    parameter int DAY_TICKS = `BPI_DAY_TICKS,
    parameter int COMM_TICKS = `BPI_COMM_TICKS,
    parameter int HOLD_TICKS = `BPI_HOLD_TICKS,
    parameter int OC_DLY_TICKS = 4,
    parameter int OC_REC_TICKS = 40,
    parameter int TRANS_COUNT = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic button,
    input wire logic ext_switch,
    input wire logic [VW-1:0] cell_v_max,
    input wire logic [VW-1:0] cell_v_min,
    input wire logic [VW-1:0] pack_v,
    input wire logic [VW-1:0] charger_v,
    input wire logic [IW-1:0] chg_i,
    input wire logic [IW-1:0] dsg_i,
    input wire logic [6:0] soc,
    input wire logic [VW-1:0] cell_ovc_th,
    input wire logic [VW-1:0] cell_ovc_rec,
    input wire logic [VW-1:0] pack_ovc_th,
    input wire logic [VW-1:0] pack_ovc_rec,
    input wire logic [VW-1:0] cell_uv_th,
    input wire logic [VW-1:0] pack_uv_th,
    input wire logic [IW-1:0] chg_oc_th,
    input wire logic [IW-1:0] dsg_oc_th,
    input wire logic [IW-1:0] trans_oc_th,
    input wire logic [IW-1:0] eff_chg_i,
    input wire logic [IW-1:0] eff_dsg_i,
    input wire logic chg_limit_en,
    output bpi_pkg::bpi_mode_t mode,
    output logic chg_en,
    output logic dsg_en,
    output logic comm_alive,
    output logic run_lamp,
    output logic alarm_lamp,
    output logic [3:0] level_lamp,
    output logic [6:0] prot_flags
);
    import bpi_pkg::*;
    localparam int DW = $clog2(DAY_TICKS + 2);
    localparam int OW = $clog2(OC_DLY_TICKS + OC_REC_TICKS + 2);
    bpi_blink_if bl ();
    bpi_blink #(.TICK_CYC(TICK_CYC)) u_blink (.clk(clk), .rst_n(rst_n), .bus(bl.gen));
    // ************************************************************
    // Pin synchronisers, button and switch
    // ************************************************************
    logic [1:0] pin_in, s1_reg, s2_reg, s3_reg, lvl_reg, lvl_d_reg;
    assign pin_in = {ext_switch, button};
    // A level counts once the second and third stages agree.
    for (genvar g = 0; g < 2; g++) begin : g_sync
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                s1_reg[g] <= 1'b0;
                s2_reg[g] <= 1'b0;
                s3_reg[g] <= 1'b0;
                lvl_reg[g] <= 1'b0;
                lvl_d_reg[g] <= 1'b0;
            end else begin
                s1_reg[g] <= pin_in[g];
                s2_reg[g] <= s1_reg[g];
                s3_reg[g] <= s2_reg[g];
                lvl_reg[g] <= (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : lvl_reg[g];
                lvl_d_reg[g] <= lvl_reg[g];
            end
        end
    end
    logic btn_rise, sw_rise, sw_fall, hold_long;
    logic [5:0] hold_reg;
    assign btn_rise = lvl_reg[0] & ~lvl_d_reg[0];
    assign sw_rise = lvl_reg[1] & ~lvl_d_reg[1];
    assign sw_fall = ~lvl_reg[1] & lvl_d_reg[1];
    assign hold_long = (hold_reg == 6'(HOLD_TICKS));
    // Held button time in ticks; saturates so one hold gives one command.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_reg <= 6'h00;
        end else if (!lvl_reg[0]) begin
            hold_reg <= 6'h00;
        end else if (bl.tick && !hold_long) begin
            hold_reg <= hold_reg + 6'h01;
        end
    end
    // ************************************************************
    // Detection terms
    // ************************************************************
    logic charger_on, charging_det, dsg_det, on, uv_any, dprot, boot_clr;
    logic ovc_reg, ovp_reg, uvc_reg, uvp_reg, occ_reg, ocd_reg, ocl_reg, boot_reg;
    bpi_mode_t mode_reg, mode_next;
    assign charger_on = {1'b0, charger_v} > ({1'b0, pack_v} + `BPI_HALF_V_MV);
    assign charging_det = charger_on && (chg_i >= eff_chg_i);
    assign dsg_det = dsg_i >= eff_dsg_i;
    assign on = (mode_reg != BPI_OFF);
    assign uv_any = uvc_reg | uvp_reg;
    assign dprot = ocd_reg | ocl_reg;
    assign boot_clr = btn_rise | sw_rise;
    // ************************************************************
    // Protection flags: the set term is last, so it wins over a clear
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovc_reg <= 1'b0;
            ovp_reg <= 1'b0;
            uvc_reg <= 1'b0;
            uvp_reg <= 1'b0;
        end else begin
            if ((cell_v_max < cell_ovc_rec && soc < `BPI_SOC_RELEASE) || dsg_det) begin
                ovc_reg <= 1'b0;
            end
            if (cell_v_max > cell_ovc_th) begin
                ovc_reg <= 1'b1;
            end
            if (pack_v < pack_ovc_rec && soc < `BPI_SOC_RELEASE) begin
                ovp_reg <= 1'b0;
            end
            if (pack_v > pack_ovc_th) begin
                ovp_reg <= 1'b1;
            end
            if (charging_det || boot_clr) begin
                uvc_reg <= 1'b0;
                uvp_reg <= 1'b0;
            end
            if (cell_v_min < cell_uv_th) begin
                uvc_reg <= 1'b1;
            end
            if (pack_v < pack_uv_th) begin
                uvp_reg <= 1'b1;
            end
        end
    end
    // ************************************************************
    // Overcurrent stages: count delay while over, then recovery delay
    // ************************************************************
    logic [OW-1:0] occ_cnt_reg, ocd_cnt_reg;
    logic occ_over, ocd_over, occ_dly_done, ocd_dly_done, occ_rec_done, ocd_rec_done;
    logic trans_over, trans_d_reg, trans_evt, trans_hit;
    logic [3:0] trans_cnt_reg;
    assign occ_over = !chg_limit_en && (chg_i > chg_oc_th);
    assign ocd_over = dsg_i > dsg_oc_th;
    assign occ_dly_done = (occ_cnt_reg == OW'(OC_DLY_TICKS));
    assign ocd_dly_done = (ocd_cnt_reg == OW'(OC_DLY_TICKS));
    assign occ_rec_done = (occ_cnt_reg == OW'(OC_REC_TICKS));
    assign ocd_rec_done = (ocd_cnt_reg == OW'(OC_REC_TICKS));
    assign trans_over = dsg_i > trans_oc_th;
    assign trans_evt = trans_over && !trans_d_reg;
    assign trans_hit = trans_evt && (trans_cnt_reg == 4'(TRANS_COUNT - 1));
    // After recovery the normal detection re-measures the current from zero.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            occ_cnt_reg <= '0;
            occ_reg <= 1'b0;
        end else if (occ_reg) begin
            occ_cnt_reg <= bl.tick ? occ_cnt_reg + 1'b1 : occ_cnt_reg;
            if (occ_rec_done || dsg_det) begin
                occ_reg <= 1'b0;
                occ_cnt_reg <= '0;
            end
        end else if (!occ_over) begin
            occ_cnt_reg <= '0;
        end else if (occ_dly_done) begin
            occ_reg <= 1'b1;
            occ_cnt_reg <= '0;
        end else begin
            occ_cnt_reg <= bl.tick ? occ_cnt_reg + 1'b1 : occ_cnt_reg;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ocd_cnt_reg <= '0;
            ocd_reg <= 1'b0;
        end else if (ocd_reg) begin
            ocd_cnt_reg <= bl.tick ? ocd_cnt_reg + 1'b1 : ocd_cnt_reg;
            if (ocd_rec_done || charging_det) begin
                ocd_reg <= 1'b0;
                ocd_cnt_reg <= '0;
            end
        end else if (!ocd_over) begin
            ocd_cnt_reg <= '0;
        end else if (ocd_dly_done) begin
            ocd_reg <= 1'b1;
            ocd_cnt_reg <= '0;
        end else begin
            ocd_cnt_reg <= bl.tick ? ocd_cnt_reg + 1'b1 : ocd_cnt_reg;
        end
    end
    // Transient events are counted on their rising edge; the latch has no timer and wins
    // over a clear that lands in the same cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trans_d_reg <= 1'b0;
            trans_cnt_reg <= 4'h0;
            ocl_reg <= 1'b0;
        end else begin
            trans_d_reg <= trans_over;
            if (boot_clr || charging_det) begin
                trans_cnt_reg <= 4'h0;
                ocl_reg <= 1'b0;
            end else if (trans_evt) begin
                trans_cnt_reg <= trans_hit ? 4'h0 : trans_cnt_reg + 4'h1;
            end
            if (trans_hit) begin
                ocl_reg <= 1'b1;
            end
        end
    end
    // ************************************************************
    // Operating mode and its timers
    // ************************************************************
    logic [DW-1:0] idle_reg;
    logic [8:0] comm_reg;
    logic idle_run, idle_done, comm_done, shut_req, prot_any;
    assign prot_any = ovc_reg | ovp_reg | uv_any | occ_reg | dprot;
    assign idle_run = (mode_reg == BPI_STANDBY) || (dprot && !charger_on);
    assign idle_done = (idle_reg == DW'(DAY_TICKS));
    assign comm_done = (comm_reg == 9'(COMM_TICKS));
    assign shut_req = hold_long || sw_fall || idle_done || comm_done;
    // Both timers run in ticks and only while the unit is on.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_reg <= '0;
            comm_reg <= 9'h000;
        end else begin
            idle_reg <= (!on || !idle_run) ? '0 : idle_reg + DW'(bl.tick);
            comm_reg <= (!on || !uv_any) ? 9'h000 : comm_reg + 9'(bl.tick);
        end
    end
    // Boot waits one cycle so flags cleared by the press can re-detect first.
    always_comb begin
        mode_next = mode_reg;
        if (!on) begin
            if (charging_det) begin
                mode_next = BPI_CHARGE;
            end else if (boot_reg && !prot_any) begin
                mode_next = BPI_STANDBY;
            end
        end else if (shut_req) begin
            mode_next = BPI_OFF;
        end else if (charging_det) begin
            mode_next = BPI_CHARGE;
        end else if (dsg_det) begin
            mode_next = BPI_DISCHARGE;
        end else begin
            mode_next = BPI_STANDBY;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= BPI_OFF;
            boot_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            boot_reg <= !on && btn_rise;
        end
    end
    // ************************************************************
    // Lamp selection and path enables
    // ************************************************************
    logic [2:0] lvl_n;
    logic [3:0] steady, chg_lvl, lamp_lvl;
    logic lamp_run, lamp_alarm;
    assign lvl_n = (soc < `BPI_SOC_Q1) ? 3'h1 : (soc < `BPI_SOC_Q2) ? 3'h2 :
        (soc < `BPI_SOC_Q3) ? 3'h3 : 3'h4;
    for (genvar k = 0; k < 4; k++) begin : g_lvl
        assign steady[k] = (3'(k) < lvl_n);
        assign chg_lvl[k] = (3'(k) + 3'h1 == lvl_n) ? bl.blink_fast_even : steady[k];
    end
    // Over-discharge and discharge faults override the mode outside charging.
    always_comb begin
        lamp_run = 1'b0;
        lamp_alarm = 1'b0;
        lamp_lvl = 4'h0;
        unique case (mode_reg)
            BPI_OFF: begin
                lamp_run = 1'b0;
            end
            BPI_STANDBY: begin
                lamp_run = 1'b1;
                lamp_lvl = steady;
            end
            BPI_CHARGE: begin
                lamp_run = 1'b1;
                lamp_alarm = occ_reg & bl.blink_slow_beacon;
                lamp_lvl = chg_lvl;
            end
            BPI_DISCHARGE: begin
                lamp_run = bl.blink_medium;
                lamp_lvl = steady;
            end
        endcase
        if (on && mode_reg != BPI_CHARGE && uv_any) begin
            lamp_run = 1'b0;
            lamp_lvl = 4'h0;
        end else if (on && mode_reg != BPI_CHARGE && dprot) begin
            lamp_run = 1'b0;
            lamp_alarm = 1'b1;
            lamp_lvl = 4'h0;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chg_en <= 1'b0;
            dsg_en <= 1'b0;
            comm_alive <= 1'b0;
            run_lamp <= 1'b0;
            alarm_lamp <= 1'b0;
            level_lamp <= 4'h0;
            prot_flags <= 7'h00;
        end else begin
            chg_en <= on && !(ovc_reg || ovp_reg || occ_reg);
            dsg_en <= on && !(uv_any || dprot);
            comm_alive <= on && uv_any;
            run_lamp <= lamp_run;
            alarm_lamp <= lamp_alarm;
            level_lamp <= lamp_lvl;
            prot_flags <= {ocl_reg, ocd_reg, occ_reg, uvp_reg, uvc_reg, ovp_reg, ovc_reg};
        end
    end
    assign mode = mode_reg;
    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_ovc_set;
        cell_v_max > cell_ovc_th |=> ovc_reg ##1 prot_flags[0];
    endproperty
    a_ovc_set: assert property (p_ovc_set) else $error("cell overcharge missed");
    property p_ovp_set;
        pack_v > pack_ovc_th |=> ovp_reg ##1 !chg_en;
    endproperty
    a_ovp_set: assert property (p_ovp_set) else $error("pack overcharge missed");
    property p_uv_off;
        pack_v < pack_uv_th |=> ##1 !dsg_en;
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("discharge not stopped");
    property p_ovc_clr;
        ovc_reg && dsg_det && !(cell_v_max > cell_ovc_th) |=> !ovc_reg;
    endproperty
    a_ovc_clr: assert property (p_ovc_clr) else $error("overcharge not cleared");
    property p_standby_en;
        mode_reg == BPI_STANDBY && !prot_any |=> chg_en && dsg_en && run_lamp;
    endproperty
    a_standby_en: assert property (p_standby_en) else $error("standby output wrong");
    property p_dprot_lamp;
        on && mode_reg != BPI_CHARGE && dprot && !uv_any |=> alarm_lamp && !run_lamp
            && level_lamp == 4'h0;
    endproperty
    a_dprot_lamp: assert property (p_dprot_lamp) else $error("fault lamps wrong");
    property p_ocl_hold;
        ocl_reg && !boot_clr && !charging_det |=> ocl_reg;
    endproperty
    a_ocl_hold: assert property (p_ocl_hold) else $error("latch released");
    property p_comm_off;
        on && comm_done |=> mode_reg == BPI_OFF ##1 !comm_alive;
    endproperty
    a_comm_off: assert property (p_comm_off) else $error("no power down");
    property p_off_dark;
        mode_reg == BPI_OFF |=> !run_lamp && !alarm_lamp && level_lamp == 4'h0;
    endproperty
    a_off_dark: assert property (p_off_dark) else $error("lamps lit while off");
    c_charge: cover property (mode_reg == BPI_OFF ##1 mode_reg == BPI_CHARGE);
    c_boot: cover property (boot_reg ##1 mode_reg == BPI_STANDBY);
    c_latch: cover property (!ocl_reg ##1 ocl_reg);
endmodule : bpi_ctrl

// ---- bpi_consts.svh ----
// Purpose: Timing counts and fixed thresholds of the pack supervisor controller.
// Assumes: 25 MHz system clock; lamp tick of 0.25 s.
// Notes: Counts measured in ticks are based on the 0.25 s lamp tick.
`ifndef BPI_CONSTS_SVH
`define BPI_CONSTS_SVH
// ************************************************************
// Clock and tick
// ************************************************************
`define BPI_CLK_HZ 25000000
`define BPI_TICK_MS 250
`define BPI_TICK_CYC ((`BPI_CLK_HZ / 1000) * `BPI_TICK_MS)
`define BPI_TICKS_PER_S 4
// ************************************************************
// Long timers in ticks
// ************************************************************
`define BPI_DAY_H 24
`define BPI_DAY_TICKS (`BPI_DAY_H * 3600 * `BPI_TICKS_PER_S)
`define BPI_COMM_MIN 1
`define BPI_COMM_TICKS (`BPI_COMM_MIN * 60 * `BPI_TICKS_PER_S)
`define BPI_HOLD_S 6
`define BPI_HOLD_TICKS (`BPI_HOLD_S * `BPI_TICKS_PER_S)
// ************************************************************
// Fixed thresholds
// ************************************************************
`define BPI_HALF_V_MV 17'h001F4
`define BPI_SOC_RELEASE 7'h60
`define BPI_SOC_Q1 7'h19
`define BPI_SOC_Q2 7'h32
`define BPI_SOC_Q3 7'h4B
`endif

// ---- bpi_pkg.sv ----
// Purpose: Types shared by the pack supervisor controller.
// Assumes: Nothing beyond the constants header.
// Notes: Operating modes only.
package bpi_pkg;
    typedef enum logic [1:0] {
        BPI_OFF,
        BPI_STANDBY,
        BPI_CHARGE,
        BPI_DISCHARGE
    } bpi_mode_t;
endpackage : bpi_pkg

// ---- bpi_blink_if.sv ----
// Purpose: Carries the common tick and blink patterns to the controller.
// Assumes: Single clock domain.
// Notes: All signals are driven by the pattern generator.
`timescale 1ns/1ns
interface bpi_blink_if;
    logic tick;
    logic blink_slow_beacon;
    logic blink_fast_even;
    logic blink_medium;
    modport gen (output tick, output blink_slow_beacon, output blink_fast_even,
        output blink_medium);
    modport use_side (input tick, input blink_slow_beacon, input blink_fast_even,
        input blink_medium);
endinterface : bpi_blink_if

// ---- bpi_blink.sv ----
// Purpose: Lamp pattern generator with a shared 0.25 s tick.
// Assumes: TICK_CYC clock cycles per tick.
// Notes: All patterns come from one phase counter so lamps stay aligned.
`timescale 1ns/1ns
`include "bpi_consts.svh"
module bpi_blink #(
    parameter int TICK_CYC = `BPI_TICK_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    bpi_blink_if.gen bus
);
    import bpi_pkg::*;
    localparam int CW = $clog2(TICK_CYC + 1);
    logic [CW-1:0] div_reg;
    logic [3:0] phase_reg;
    logic tick_reg;
    logic wrap;
    // ************************************************************
    // Tick divider and 4 s phase counter
    // ************************************************************
    assign wrap = (div_reg == CW'(TICK_CYC - 1));
    // The phase advances once per tick; one lap is sixteen quarter seconds.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
            phase_reg <= 4'h0;
            tick_reg <= 1'b0;
        end else begin
            div_reg <= wrap ? '0 : div_reg + 1'b1;
            tick_reg <= wrap;
            if (tick_reg) begin
                phase_reg <= phase_reg + 4'h1;
            end
        end
    end
    // Lit 0.25 of 4 s, 0.5 of 1 s, and 0.5 of 2 s.
    assign bus.tick = tick_reg;
    assign bus.blink_slow_beacon = (phase_reg == 4'h0);
    assign bus.blink_fast_even = ~phase_reg[1];
    assign bus.blink_medium = (phase_reg[2:0] < 3'h2);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_tick_single;
        tick_reg |=> !tick_reg;
    endproperty
    a_tick_single: assert property (p_tick_single) else $error("tick too long");
    // The beacon may only go dark on a tick, so it is never lit for less than one tick.
    property p_beacon_len;
        $fell(bus.blink_slow_beacon) |-> $past(tick_reg);
    endproperty
    a_beacon_len: assert property (p_beacon_len) else $error("beacon dropped early");
endmodule : bpi_blink

// ---- bpi_pack_model.sv ----
// Purpose: Cells, pack and load seen by the pack supervisor controller.
// Assumes: Load current changes on the falling edge of clk.
// Notes: A disabled discharge path carries no load current.
`timescale 1ns/1ns
module bpi_pack_model (
    input wire logic clk,
    input wire logic dsg_en,
    input wire logic [15:0] cell_hi,
    input wire logic pack_low,
    input wire logic load_on,
    output logic [15:0] cell_v_max,
    output logic [15:0] cell_v_min,
    output logic [15:0] pack_v,
    output logic [15:0] dsg_i
);
    // Voltages follow the bench's scenario; the weakest cell stays healthy.
    assign cell_v_max = cell_hi;
    assign cell_v_min = 16'h0C80;
    assign pack_v = pack_low ? 16'h4A38 : 16'h6720;
    // The load draws only through an enabled path, so a trip really stops the current.
    initial dsg_i = 16'h0000;
    always @(negedge clk) begin
        dsg_i <= (load_on && dsg_en) ? 16'h0096 : 16'h0000;
    end
endmodule : bpi_pack_model

// ---- battery_protection_indicator_ctrl_bench.sv ----
// Purpose: Self-checking bench of the pack supervisor controller.
// Assumes: Short tick and timer parameters; a charger is applied only near the end.
// Notes: Inputs change on the falling edge of clk.
`timescale 1ns/1ns
module battery_protection_indicator_ctrl_bench;
    import bpi_pkg::*;
    logic clk = 0, rst_n = 0, button = 0, load_on = 0, pack_low = 0, ovc_exp = 0;
    logic ext_switch = 0, chg_limit_en = 0;
    logic [6:0] soc = 7'h32;
    logic [15:0] charger_v = 16'h0000, chg_i = 16'h0000, cell_uv = 16'h09C4, oc_th = 16'h0064;
    logic [15:0] trans_th = 16'h012C, eff_i = 16'h0005;
    logic [15:0] cell_hi = 16'h0CE4, v, vmax, vmin, pack_v, dsg_i;
    logic [15:0] corner [4] = '{16'h0E42, 16'h0E43, 16'h0D48, 16'h0D47};
    bpi_mode_t mode;
    logic chg_en, dsg_en, comm_alive, run_lamp, alarm_lamp;
    logic [3:0] level_lamp;
    logic [6:0] prot_flags;
    int errors = 0, n_checks = 0;
    // Clock of 40 ns.
    always #20 clk = ~clk;
    bpi_pack_model pack (.clk(clk), .dsg_en(dsg_en), .cell_hi(cell_hi), .pack_low(pack_low),
        .load_on(load_on), .cell_v_max(vmax), .cell_v_min(vmin), .pack_v(pack_v), .dsg_i(dsg_i));
    bpi_ctrl #(.TICK_CYC(4), .DAY_TICKS(2000), .COMM_TICKS(10), .HOLD_TICKS(3),
        .OC_REC_TICKS(6)) uut (.clk(clk), .rst_n(rst_n), .button(button),
        .ext_switch(ext_switch), .cell_v_max(vmax), .cell_v_min(vmin), .pack_v(pack_v),
        .charger_v(charger_v), .chg_i(chg_i), .dsg_i(dsg_i), .soc(soc),
        .cell_ovc_th(16'h0E42), .cell_ovc_rec(16'h0D48), .pack_ovc_th(16'h7148),
        .pack_ovc_rec(16'h6B6C), .cell_uv_th(cell_uv), .pack_uv_th(16'h4E20),
        .chg_oc_th(oc_th), .dsg_oc_th(oc_th), .trans_oc_th(trans_th), .eff_chg_i(eff_i),
        .eff_dsg_i(eff_i), .chg_limit_en(chg_limit_en), .mode(mode), .chg_en(chg_en),
        .dsg_en(dsg_en), .comm_alive(comm_alive), .run_lamp(run_lamp),
        .alarm_lamp(alarm_lamp), .level_lamp(level_lamp), .prot_flags(prot_flags));
    // Overcharge flag with hysteresis: set above the limit, cleared below recovery.
    function automatic logic ovc_next(input logic cur, input logic [15:0] x);
        return (x > 16'h0E42) ? 1'b1 : ((x < 16'h0D48) ? 1'b0 : cur);
    endfunction : ovc_next
    // Level lamps lit from the bottom, one more per started quarter of charge.
    function automatic logic [3:0] lvl_exp(input logic [6:0] s);
        return (s < 7'h19) ? 4'h1 : (s < 7'h32) ? 4'h3 : (s < 7'h4B) ? 4'h7 : 4'hF;
    endfunction : lvl_exp
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // Short press, well under the hold time that would mean shutdown.
    task automatic press;
        button = 1;
        cyc(2);
        button = 0;
        cyc(8);
    endtask : press
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    // The tests need about 350 cycles, so this limit only trips on a hang.
    initial begin
        #100000;
        errors++;
        print_verdict();
    end
    // Main sequence: boot, level lamps, overcharge, overcurrent, undervoltage, transient
    // latch, charging and switch shutdown.
    initial begin
        void'($urandom(32'h837C66ED));
        cyc(8);
        check(prot_flags, 16'h0000);
        rst_n = 1;
        press();
        check(mode, BPI_STANDBY);
        check({alarm_lamp, chg_en, dsg_en}, 3'h3);
        for (int k = 0; k < 6; k++) begin
            soc = (k < 3) ? 7'h18 + 7'(k) : 7'($urandom_range(100));
            cyc(2);
            check({run_lamp, level_lamp}, {1'b1, lvl_exp(soc)});
        end
        soc = 7'h32;
        for (int k = 0; k < 12; k++) begin
            v = (k < 4) ? corner[k] : 16'h0CE4 + 16'($urandom_range(500));
            cell_hi = v;
            cyc(4);
            ovc_exp = ovc_next(ovc_exp, v);
            check(prot_flags[0], ovc_exp);
            check(chg_en, !ovc_exp);
        end
        cell_hi = 16'h0E43;
        cyc(4);
        cell_hi = 16'h0D50;
        load_on = 1;
        cyc(3);
        check(prot_flags[0], 1'b0);
        check({mode, alarm_lamp, level_lamp}, {BPI_DISCHARGE, 1'b0, lvl_exp(7'h32)});
        cyc(24);
        check({prot_flags[5], dsg_en, alarm_lamp}, 3'h5);
        check({run_lamp, level_lamp}, 5'h00);
        load_on = 0;
        cyc(40);
        check({prot_flags[5], dsg_en}, 2'h1);
        pack_low = 1;
        cyc(4);
        check({prot_flags[3], dsg_en, comm_alive}, 3'h5);
        cyc(60);
        check({mode, comm_alive}, {BPI_OFF, 1'b0});
        check({run_lamp, alarm_lamp, level_lamp}, 6'h00);
        press();
        check(mode, BPI_OFF);
        pack_low = 0;
        press();
        check(mode, BPI_STANDBY);
        // Cell undervoltage while on, released by a short press.
        cell_uv = 16'h0C81;
        cyc(4);
        check({prot_flags[2], dsg_en}, 2'h2);
        cell_uv = 16'h09C4;
        press();
        check({mode, prot_flags[2], dsg_en}, {BPI_STANDBY, 2'h1});
        // Three short load pulses above the transient limit close the latch.
        trans_th = 16'h0050;
        repeat (3) begin
            load_on = 1;
            cyc(2);
            load_on = 0;
            cyc(2);
        end
        cyc(2);
        check({prot_flags[6], dsg_en, alarm_lamp}, 3'h5);
        // A charger releases the latch, then overcurrent trips with limiting off.
        charger_v = 16'h6A00;
        chg_i = 16'h0032;
        cyc(3);
        check({mode, prot_flags[6], chg_en}, {BPI_CHARGE, 2'h1});
        chg_i = 16'h00C8;
        cyc(24);
        check({prot_flags[4], chg_en}, 2'h2);
        chg_limit_en = 1;
        cyc(30);
        check({prot_flags[4], chg_en}, 2'h1);
        charger_v = 16'h0000;
        chg_i = 16'h0000;
        ext_switch = 1;
        cyc(8);
        ext_switch = 0;
        cyc(8);
        check(mode, BPI_OFF);
        print_verdict();
    end
endmodule : battery_protection_indicator_ctrl_bench
